// file: verilog/pport_defs.svh
// constants of the parallel port register block
// assumes inclusion by bare name from the design files
`ifndef PPORT_DEFS_SVH
`define PPORT_DEFS_SVH

// port offsets from the base address
`define OFS_DATA      3'h0
`define OFS_STATUS    3'h1
`define OFS_CONTROL   3'h2
`define OFS_EPP_ADDR  3'h3
`define OFS_EPP_DATA0 3'h4
// base compare ignores these low address bits
`define OFS_BITS      3

// status bit positions
`define ST_TIMEOUT    0
`define ST_ERROR      3
`define ST_ONLINE     4
`define ST_PAPER      5
`define ST_ACK        6
`define ST_READY      7

// control bit positions
`define CT_STROBE     0
`define CT_FEED       1
`define CT_INIT       2
`define CT_SELECT     3
`define CT_IRQ_EN     4
`define CT_DIR        5
`define CT_WIDTH      6

// reset values
`define DATA_RESET    8'h00
`define CTRL_RESET    6'h00
`define EPP_RESET     8'h00
`define IDLE_BUS      8'h00
// strobes and active-low status pins idle high
`define STAT_SYNC_RESET 7'h72

`endif

// file: verilog/pport_pkg.sv
// types shared by the parallel port register block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package pport_pkg;
  typedef enum logic [1:0] {
    mode_printer = 2'h0,
    mode_bidir   = 2'h1,
    mode_epp     = 2'h2,
    mode_ecp     = 2'h3
  } port_mode_t;

  typedef struct packed {
    logic error_n;
    logic online;
    logic paper_end;
    logic ack_n;
    logic busy;
  } printer_status_t;

  typedef struct packed {
    logic       valid;
    logic       addr_cycle;
    logic       write;
    logic [1:0] data_sel;
    logic [7:0] wdata;
  } epp_request_t;

  typedef enum logic [2:0] {
    st_idle  = 3'h1,
    st_read  = 3'h2,
    st_write = 3'h4
  } access_state_t;
endpackage
`default_nettype wire

// file: verilog/pin_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes a synchronous active-high reset
`default_nettype none
module pin_sync #(
  parameter int        WIDTH = 1,
  parameter bit [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta  <= RESET_VALUE;
      q_out <= RESET_VALUE;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// file: verilog/rise_detect.sv
// rising edge detector on an already synchronised level
// assumes the input is in the mclk_in domain
`default_nettype none
module rise_detect #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out
);
  logic [WIDTH-1:0] prev;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // no false edge out of reset on an idle-high pin
      prev <= '1;
    end else begin
      prev <= level_in;
    end
  end

  assign rise_out = level_in & ~prev;
endmodule // rise_detect
`default_nettype wire

// file: verilog/parallel_port_host_registers.sv
// host register block of a multi-mode parallel port
// assumes host strobes, address and data arrive asynchronously;
// mode, base address and the cycle engine signals share mclk_in
`include "pport_defs.svh"
`default_nettype none

// Overview of operation
// - eight byte ports decoded at consecutive offsets from a programmable base.
// - data, status, control always; address and four data ports only in EPP mode.
// - data register clears on reset, captures on write strobe end, drives pins.
// - data port read returns live pin levels, not a stored copy.
// - status value captured at start of a read and held until it ends.
// - status bit 0 reads one once a cycle timeout was flagged.
// - timeout flag cleared by reset or by writing one in EPP mode; zero leaves it.
// - status bits 1 and 2 always read zero.
// - status bit 3 is the error input level as it stands.
// - status bit 4 is the online input level as it stands.
// - status bit 5 is the paper end input level as it stands.
// - status bit 6 is the acknowledge input level as it stands.
// - status bit 7 is the busy input inverted.
// - reset clears control bits 0 to 5; bits 6 and 7 read zero.
// - control bit 0 drives the strobe pin inverted.
// - control bit 1 drives the line feed pin inverted.
// - data and control writable always; status writable only in EPP mode.
// - control bit 2 drives the init pin without inversion.
// - control bit 3 drives the select pin inverted.
// - with control bit 4 set, acknowledge rising edge raises the interrupt.
// - control bit 5 sets pin direction except printer mode, always output.
module parallel_port_host_registers
  import pport_pkg::*;
(
  input  wire logic            mclk_in,
  input  wire logic            rst_in,
  input  wire logic [15:0]     base_addr_in,
  input  wire port_mode_t      mode_in,
  input  wire logic [15:0]     host_addr_in,
  input  wire logic            host_ior_n_in,
  input  wire logic            host_iow_n_in,
  input  wire logic [7:0]      host_data_in,
  output var  logic [7:0]      host_data_out,
  output logic                 host_data_oe_out,
  input  wire logic [7:0]      parallel_data_pins_in,
  output var  logic [7:0]      parallel_data_pins_out,
  output logic                 parallel_data_pins_oe_out,
  input  wire printer_status_t status_pins_in,
  output logic                 strobe_n_out,
  output logic                 line_feed_request_n_out,
  output logic                 printer_init_request_n_out,
  output logic                 printer_select_request_n_out,
  output var  logic            irq_out,
  input  wire logic            epp_timeout_in,
  input  wire logic            epp_busy_in,
  input  wire logic [7:0]      epp_rdata_in,
  output var  epp_request_t    epp_req_out
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [15:0]     addr_s;
  logic [7:0]      wdata_s;
  logic [7:0]      pins_s;
  logic            ior_n_s;
  logic            iow_n_s;
  printer_status_t stat_s;
  logic            ack_rise;

  pin_sync #(.WIDTH(16)) u_addr_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (host_addr_in),
    .q_out   (addr_s)
  );

  pin_sync #(.WIDTH(16)) u_data_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({parallel_data_pins_in, host_data_in}),
    .q_out   ({pins_s, wdata_s})
  );

  pin_sync #(.WIDTH(7), .RESET_VALUE(`STAT_SYNC_RESET)) u_ctl_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({host_ior_n_in, host_iow_n_in, status_pins_in}),
    .q_out   ({ior_n_s, iow_n_s, stat_s})
  );

  rise_detect #(.WIDTH(1)) u_ack_edge (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .level_in (stat_s.ack_n),
    .rise_out (ack_rise)
  );

  // ************************************************************
  // host access sequencing
  // ************************************************************
  access_state_t state;
  access_state_t next_state;
  logic [2:0]    ofs;
  logic [2:0]    next_ofs;
  logic          hit;
  logic          rd_start;
  logic          wr_start;
  logic          wr_commit;
  logic          epp_ok;
  logic          cur_epp;

  assign hit      = addr_s[15:`OFS_BITS] == base_addr_in[15:`OFS_BITS];
  assign epp_ok   = mode_in == mode_epp;
  assign rd_start = state == st_idle && hit && !ior_n_s;
  assign wr_start = state == st_idle && hit && !rd_start && !iow_n_s;
  assign wr_commit = state == st_write && iow_n_s;
  assign cur_epp  = ofs >= `OFS_EPP_ADDR;

  always_comb begin
    next_state = state;
    next_ofs   = ofs;
    unique case (state)
      st_idle: begin
        if (rd_start) begin
          next_state = st_read;
          next_ofs   = addr_s[2:0];
        end else if (wr_start) begin
          next_state = st_write;
          next_ofs   = addr_s[2:0];
        end
      end
      st_read: begin
        if (ior_n_s) begin
          next_state = st_idle;
        end
      end
      st_write: begin
        if (iow_n_s) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= st_idle;
      ofs   <= `OFS_DATA;
    end else begin
      state <= next_state;
      ofs   <= next_ofs;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]            data_latch;
  logic [7:0]            next_data_latch;
  logic [`CT_WIDTH-1:0]  ctrl;
  logic [`CT_WIDTH-1:0]  next_ctrl;
  logic                  epp_timeout_flag;
  logic                  next_epp_timeout_flag;
  logic [7:0]            epp_latch;
  logic [7:0]            next_epp_latch;
  logic [7:0]            status_word;
  logic [7:0]            next_host_data;
  logic [7:0]            next_pins;
  logic                  next_irq;
  epp_request_t          next_req;
  logic                  epp_access;

  always_comb begin
    status_word               = '0;
    status_word[`ST_TIMEOUT]  = epp_timeout_flag;
    status_word[`ST_ERROR]    = stat_s.error_n;
    status_word[`ST_ONLINE]   = stat_s.online;
    status_word[`ST_PAPER]    = stat_s.paper_end;
    status_word[`ST_ACK]      = stat_s.ack_n;
    status_word[`ST_READY]    = ~stat_s.busy;
  end

  // cycle request only while EPP mode is selected
  assign epp_access = (rd_start || wr_start) && addr_s[2:0] >= `OFS_EPP_ADDR && epp_ok;

  always_comb begin
    next_data_latch       = data_latch;
    next_ctrl             = ctrl;
    next_epp_latch        = epp_latch;
    next_epp_timeout_flag = epp_timeout_flag;
    if (wr_commit) begin
      if (ofs == `OFS_DATA) begin
        next_data_latch = wdata_s;
      end
      if (ofs == `OFS_CONTROL) begin
        next_ctrl = wdata_s[`CT_WIDTH-1:0];
      end
      if (ofs == `OFS_STATUS && epp_ok && wdata_s[`ST_TIMEOUT]) begin
        next_epp_timeout_flag = 1'b0;
      end
    end
    if (wr_start && epp_access) begin
      next_epp_latch = wdata_s;
    end
    // a timeout in the clearing cycle is kept
    if (epp_timeout_in) begin
      next_epp_timeout_flag = 1'b1;
    end
  end

  always_comb begin
    next_host_data = host_data_out;
    if (rd_start) begin
      unique case (addr_s[2:0])
        `OFS_DATA:    next_host_data = pins_s;
        `OFS_STATUS:  next_host_data = status_word;
        `OFS_CONTROL: next_host_data = {2'b00, ctrl};
        default:      next_host_data = epp_ok ? epp_rdata_in : `IDLE_BUS;
      endcase
    end else if (state == st_read) begin
      if (ofs == `OFS_DATA) begin
        next_host_data = pins_s;
      end else if (cur_epp && epp_ok) begin
        next_host_data = epp_rdata_in;
      end
    end
  end

  always_comb begin
    next_pins          = (epp_busy_in && epp_ok) ? epp_latch : data_latch;
    next_irq           = ctrl[`CT_IRQ_EN] && ack_rise;
    next_req           = '0;
    next_req.valid     = epp_access;
    next_req.addr_cycle = addr_s[2:0] == `OFS_EPP_ADDR;
    next_req.write     = wr_start;
    next_req.data_sel  = 2'(addr_s[2:0] - `OFS_EPP_DATA0);
    next_req.wdata     = wdata_s;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      data_latch             <= `DATA_RESET;
      ctrl                   <= `CTRL_RESET;
      epp_timeout_flag       <= 1'b0;
      epp_latch              <= `EPP_RESET;
      host_data_out          <= `IDLE_BUS;
      parallel_data_pins_out <= `DATA_RESET;
      irq_out                <= 1'b0;
      epp_req_out            <= '0;
    end else begin
      data_latch             <= next_data_latch;
      ctrl                   <= next_ctrl;
      epp_timeout_flag       <= next_epp_timeout_flag;
      epp_latch              <= next_epp_latch;
      host_data_out          <= next_host_data;
      parallel_data_pins_out <= next_pins;
      irq_out                <= next_irq;
      epp_req_out            <= next_req;
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // cycle ports outside EPP mode leave the host bus undriven
  assign host_data_oe_out = state == st_read && (!cur_epp || epp_ok);
  assign parallel_data_pins_oe_out = mode_in == mode_printer || !ctrl[`CT_DIR];
  assign strobe_n_out                 = ~ctrl[`CT_STROBE];
  assign line_feed_request_n_out      = ~ctrl[`CT_FEED];
  assign printer_init_request_n_out   = ctrl[`CT_INIT];
  assign printer_select_request_n_out = ~ctrl[`CT_SELECT];

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_write_end(logic [2:0] o);
    state == st_write && iow_n_s && ofs == o;
  endsequence

  property p_data_write;
    @(posedge mclk_in) disable iff (rst_in)
    s_write_end(`OFS_DATA) |=> data_latch == $past(wdata_s) ##1 parallel_data_pins_out == $past(data_latch)
      || $past(epp_busy_in);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write not captured");

  property p_data_reset;
    @(posedge mclk_in) rst_in |=> data_latch == `DATA_RESET && ctrl == `CTRL_RESET && !epp_timeout_flag;
  endproperty
  a_data_reset: assert property (p_data_reset) else $error("reset values wrong");

  property p_status_hold;
    @(posedge mclk_in) disable iff (rst_in)
    state == st_read && $past(state) == st_read && ofs == `OFS_STATUS |-> $stable(host_data_out);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved during read");

  property p_timeout_set;
    @(posedge mclk_in) disable iff (rst_in)
    epp_timeout_in |=> epp_timeout_flag;
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");

  property p_timeout_clear;
    @(posedge mclk_in) disable iff (rst_in)
    s_write_end(`OFS_STATUS) ##0 (epp_ok && wdata_s[0] && !epp_timeout_in) |=> !epp_timeout_flag;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("timeout flag not cleared");

  property p_strobe_pin;
    @(posedge mclk_in) disable iff (rst_in)
    s_write_end(`OFS_CONTROL) |=> strobe_n_out == !$past(wdata_s[0])
      && printer_init_request_n_out == $past(wdata_s[2]);
  endproperty
  a_strobe_pin: assert property (p_strobe_pin) else $error("control pins wrong");

  property p_ctrl_read;
    @(posedge mclk_in) disable iff (rst_in)
    rd_start && addr_s[2:0] == `OFS_CONTROL |=> host_data_out[7:6] == 2'b00 && host_data_oe_out;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control high bits not zero");

  property p_printer_dir;
    @(posedge mclk_in) disable iff (rst_in)
    mode_in == mode_printer |-> parallel_data_pins_oe_out;
  endproperty
  a_printer_dir: assert property (p_printer_dir) else $error("printer mode not driving");

  property p_no_epp_outside;
    @(posedge mclk_in) disable iff (rst_in)
    (rd_start || wr_start) && addr_s[2:0] >= `OFS_EPP_ADDR && !epp_ok |=> !epp_req_out.valid;
  endproperty
  a_no_epp_outside: assert property (p_no_epp_outside) else $error("cycle started outside EPP");

  property p_ack_irq;
    @(posedge mclk_in) disable iff (rst_in)
    $rose(stat_s.ack_n) |=> irq_out == $past(ctrl[`CT_IRQ_EN]);
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("ack interrupt wrong");

endmodule // parallel_port_host_registers
`default_nettype wire

// file: bench/printer_model.sv
// printer side of the cable: resolves the eight data pins
// assumes the bench sets whether the printer drives and with what byte
`default_nettype none
module printer_model
  import pport_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic [7:0] host_pins_in,
  input  wire logic       host_oe_in,
  input  wire logic       drive_en_in,
  input  wire logic [7:0] drive_val_in,
  output logic      [7:0] pins_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  // released pins float: show a pattern that flips every cycle
  always_ff @(posedge mclk_in) begin
    last <= pins_level_out;
  end
  assign pins_level_out = host_oe_in ? host_pins_in : (drive_en_in ? drive_val_in : ~last);
endmodule // printer_model
`default_nettype wire

// file: bench/parallel_port_host_registers_tb_top.sv
// self-checking bench of the parallel port host register block
// assumes the package, the design and the printer model compile first
`default_nettype none
module parallel_port_host_registers_tb_top
  import pport_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    port_mode_t mode;
    logic [3:0] ofs;
    logic [7:0] wd;
    logic [7:0] rd;
  } row_t;
  localparam logic [15:0] BASE = 16'h0240;
  localparam row_t ROWS [6] = '{'{mode_printer, 4'h0, 8'hA5, 8'hA5}, '{mode_printer, 4'h0, 8'h5A, 8'h5A},
                                '{mode_printer, 4'h2, 8'hFF, 8'h3F}, '{mode_bidir, 4'h2, 8'h0A, 8'h0A},
                                '{mode_epp, 4'h2, 8'h15, 8'h15}, '{mode_epp, 4'h0, 8'hC3, 8'hC3}};
  logic            mclk = 1'h0, rst = 1'h1, ior_n = 1'h1, iow_n = 1'h1, tmo = 1'h0, drv_en = 1'h0;
  port_mode_t      mode = mode_printer;
  logic [15:0]     haddr = 16'h0000;
  logic [7:0]      hdin = 8'h00, drv_val = 8'h00, hdout, pins_in, pins_out;
  logic            hdoe, pins_oe, strobe_n, feed_n, init_n, sel_n, irq;
  printer_status_t st = 5'h00;
  epp_request_t    req, last_req;
  int              miscompares = 0, n_tests = 0, n_irq = 0, n_req = 0, cycles = 0;

  parallel_port_host_registers dut (.mclk_in(mclk), .rst_in(rst), .base_addr_in(BASE), .mode_in(mode),
    .host_addr_in(haddr), .host_ior_n_in(ior_n), .host_iow_n_in(iow_n), .host_data_in(hdin),
    .host_data_out(hdout), .host_data_oe_out(hdoe), .parallel_data_pins_in(pins_in),
    .parallel_data_pins_out(pins_out), .parallel_data_pins_oe_out(pins_oe), .status_pins_in(st),
    .strobe_n_out(strobe_n), .line_feed_request_n_out(feed_n), .printer_init_request_n_out(init_n),
    .printer_select_request_n_out(sel_n), .irq_out(irq), .epp_timeout_in(tmo), .epp_busy_in(1'h0),
    .epp_rdata_in(8'h3C), .epp_req_out(req));
  printer_model far_end (.mclk_in(mclk), .host_pins_in(pins_out), .host_oe_in(pins_oe),
    .drive_en_in(drv_en), .drive_val_in(drv_val), .pins_level_out(pins_in));

  always #4 mclk = ~mclk;
  // pulses are counted mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    cycles++;
    if (irq === 1'h1) n_irq++;
    if (req.valid === 1'h1) begin
      n_req++;
      last_req = req;
    end
    if (cycles == 8000) begin
      miscompares++;
      final_report();
    end
  end

  // ************
  // helpers
  // ************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    @(posedge mclk);
    haddr <= BASE + {12'h000, o};
    hdin <= d;
    iow_n <= 1'h0;
    repeat (4) @(posedge mclk);
    iow_n <= 1'h1;
    repeat (8) @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] o, output logic [7:0] d, output logic seen);
    int k;
    @(posedge mclk);
    haddr <= BASE + {12'h000, o};
    ior_n <= 1'h0;
    seen = 1'h0;
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      #1;
      if (hdoe === 1'h1) seen = 1'h1;
    end
    d = hdout;
    @(posedge mclk);
    ior_n <= 1'h1;
    repeat (8) @(posedge mclk);
  endtask
  task automatic set_mode(input port_mode_t m);
    @(posedge mclk);
    mode <= m;
    repeat (3) @(posedge mclk);
  endtask
  function automatic logic [7:0] stat(input printer_status_t s, input logic f);
    return {~s.busy, s.ack_n, s.paper_end, s.online, s.error_n, 2'b00, f};
  endfunction
  function automatic logic [7:0] ctl_pins(input logic [7:0] v);
    return {4'h0, ~v[3], v[2], ~v[1], ~v[0]};
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    logic [7:0] d;
    logic       seen;
    int         i, n0;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    chk(pins_out, 8'h00, "pins after reset");
    chk({4'h0, sel_n, init_n, feed_n, strobe_n}, ctl_pins(8'h00), "control after reset");
    for (i = 0; i < 6; i++) begin
      set_mode(ROWS[i].mode);
      wr(ROWS[i].ofs, ROWS[i].wd);
      rd(ROWS[i].ofs, d, seen);
      chk(d, ROWS[i].rd, "row readback");
    end
    set_mode(mode_printer);
    chk({7'h00, pins_oe}, 8'h01, "printer mode drives");
    for (i = 0; i < 4; i++) begin
      wr(4'h2, 8'h01 << i);
      chk({4'h0, sel_n, init_n, feed_n, strobe_n}, ctl_pins(8'h01 << i), "control pins");
    end
    for (i = 0; i < 4; i++) begin
      st <= 5'h15 ^ (5'h0B * i[4:0]);
      rd(4'h1, d, seen);
      chk(d, stat(5'h15 ^ (5'h0B * i[4:0]), 1'h0), "status bits");
    end
    st <= 5'h15;
    repeat (4) @(posedge mclk);
    haddr <= BASE + 16'h0001;
    ior_n <= 1'h0;
    repeat (5) @(posedge mclk);
    st <= 5'h0A;
    repeat (6) @(posedge mclk);
    #1;
    chk(hdout, stat(5'h15, 1'h0), "status held in read");
    @(posedge mclk);
    ior_n <= 1'h1;
    repeat (8) @(posedge mclk);
    set_mode(mode_epp);
    @(posedge mclk);
    tmo <= 1'h1;
    @(posedge mclk);
    tmo <= 1'h0;
    rd(4'h1, d, seen);
    chk(d, stat(5'h0A, 1'h1), "timeout set");
    wr(4'h1, 8'h00);
    rd(4'h1, d, seen);
    chk(d, stat(5'h0A, 1'h1), "zero write keeps flag");
    set_mode(mode_printer);
    wr(4'h1, 8'h01);
    set_mode(mode_epp);
    rd(4'h1, d, seen);
    chk(d, stat(5'h0A, 1'h1), "status write outside epp");
    wr(4'h1, 8'h01);
    rd(4'h1, d, seen);
    chk(d, stat(5'h0A, 1'h0), "one write clears flag");
    for (i = 3; i < 8; i++) begin
      n0 = n_req;
      wr(i[3:0], 8'h90 + i[7:0]);
      chk(8'(n_req - n0), 8'h01, "epp request count");
      chk({5'h00, last_req.write, last_req.addr_cycle, 1'h0}, {6'h01, i == 3, 1'h0}, "epp kind");
      chk(last_req.wdata, 8'h90 + i[7:0], "epp data");
      if (i > 3) chk({6'h00, last_req.data_sel}, 8'(i - 4), "epp port select");
    end
    n0 = n_req;
    rd(4'h4, d, seen);
    chk(d, 8'h3C, "epp port read");
    chk({7'h00, seen}, 8'h01, "epp read driven");
    chk({6'h00, last_req.write, 8'(n_req - n0) == 8'h01}, 8'h01, "epp read request");
    rd(4'h0, d, seen);
    chk(d, 8'hC3, "epp write keeps data latch");
    set_mode(mode_printer);
    n0 = n_req;
    wr(4'h4, 8'h77);
    rd(4'h5, d, seen);
    chk({7'h00, seen}, 8'h00, "epp read outside epp undriven");
    wr(4'h8, 8'h11);
    rd(4'h0, d, seen);
    chk(d, 8'hC3, "data latch kept");
    chk(8'(n_req - n0), 8'h00, "no epp request outside epp");
    set_mode(mode_bidir);
    drv_en <= 1'h1;
    drv_val <= 8'h6E;
    wr(4'h2, 8'h20);
    chk({7'h00, pins_oe}, 8'h00, "bidir input direction");
    rd(4'h0, d, seen);
    chk(d, 8'h6E, "live pins read");
    drv_en <= 1'h0;
    wr(4'h2, 8'h10);
    chk({7'h00, pins_oe}, 8'h01, "bidir output direction");
    for (i = 0; i < 2; i++) begin
      n0 = n_irq;
      st <= 5'h00;
      repeat (6) @(posedge mclk);
      st <= 5'h02;
      repeat (10) @(posedge mclk);
      chk(8'(n_irq - n0), 8'(1 - i), "ack interrupt pulses");
      wr(4'h2, 8'h00);
    end
    wr(4'h2, 8'h0F);
    @(posedge mclk);
    rst <= 1'h1;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    #1;
    chk(pins_out, 8'h00, "pins after second reset");
    chk({4'h0, sel_n, init_n, feed_n, strobe_n}, ctl_pins(8'h00), "control after second reset");
    final_report();
  end
endmodule // parallel_port_host_registers_tb_top
`default_nettype wire
